// ### hw/lsm_consts.svh
// constants for the led status mux: offsets, fields, resets, timing
//------------------------------------------------------------------
//------------------------------------------------------------------
`ifndef LSM_CONSTS_SVH
`define LSM_CONSTS_SVH

// byte offsets on the register bus
`define LSM_ADDR_W 4
`define LSM_OFS_TWO 4'h0
`define LSM_OFS_THREE 4'h4

// control field positions
`define LSM_B_COL 0
`define LSM_B_JAB 1
`define LSM_B_RCV 2
`define LSM_B_POL 3
`define LSM_B_TX 4
`define LSM_B_MATCH 5
`define LSM_B_PSE 7
`define LSM_B_INV 14
`define LSM_B_RAW 15

// reset values and writable bit masks
`define LSM_RST_TWO 16'h0088
`define LSM_RST_THREE 16'h0090
`define LSM_WMASK_TWO 16'h40BF
`define LSM_WMASK_THREE 16'h00BF

// stretch time and clock period in ns
`define LSM_STRETCH_NS 100000
`define LSM_CLK_NS 50
`define LSM_STRETCH_CYC (`LSM_STRETCH_NS / `LSM_CLK_NS)
`define LSM_CNT_W 11

// axi responses
`define LSM_RESP_OKAY 2'h0
`define LSM_RESP_SLVERR 2'h2

`endif

// ### hw/lsm_pkg.sv
// types shared by the led status mux
package lsm_pkg;
	// one control register image
	typedef logic [15:0] lsm_reg_t;
	// read channel state, one-hot
	typedef enum logic [1:0] {
		LSM_RD_IDLE = 2'h1,
		LSM_RD_RESP = 2'h2
	} lsm_rd_state_t;
endpackage : lsm_pkg

// ### hw/lsm_led_status_mux.sv
// programmable led status mux with axi4-lite control registers
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`include "lsm_consts.svh"

module lsm_led_status_mux (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// write address channel
	input wire logic [`LSM_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// write data channel
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// write response channel
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// read address channel
	input wire logic [`LSM_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// read data channel
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// network events, synchronous levels
	input wire logic tx_activity,
	input wire logic rx_activity,
	input wire logic rx_addr_match,
	input wire logic polarity_good,
	input wire logic jabber,
	input wire logic collision,
	// indicator pins
	output logic indicator_pin_two,
	output logic indicator_pin_three
);
	import lsm_pkg::*;

	//------------------------------------------------------------------
	// helper functions
	//------------------------------------------------------------------
	// address decode: bit 0 led two, bit 1 led three, zero unmapped
	function automatic logic [1:0] lsm_sel(input logic [`LSM_ADDR_W-1:0] a);
		lsm_sel = {a == `LSM_OFS_THREE, a == `LSM_OFS_TWO};
	endfunction : lsm_sel

	// byte-lane merge limited to writable bits
	function automatic lsm_reg_t lsm_merge(input lsm_reg_t old, input lsm_reg_t d,
			input logic [1:0] strb, input lsm_reg_t mask);
		lsm_reg_t m;
		m = {{8{strb[1]}}, {8{strb[0]}}} & mask;
		lsm_merge = (old & ~m) | (d & m);
	endfunction : lsm_merge

	//------------------------------------------------------------------
	// state declarations
	//------------------------------------------------------------------
	lsm_reg_t ctrl [2]; // control registers, index 0 two, 1 three
	lsm_reg_t next_ctrl [2];
	logic [1:0] raw; // unstretched or-state per led
	logic [1:0] lit; // stretched assertion per led
	logic aw_held; // write address captured
	logic next_aw_held;
	logic w_held; // write data captured
	logic next_w_held;
	logic [`LSM_ADDR_W-1:0] aw_addr; // captured write address
	logic [`LSM_ADDR_W-1:0] next_aw_addr;
	lsm_reg_t w_data; // captured low half of write data
	lsm_reg_t next_w_data;
	logic [1:0] w_strb; // captured low byte strobes
	logic [1:0] next_w_strb;
	logic bvalid; // write answer pending
	logic next_bvalid;
	logic [1:0] bresp;
	logic [1:0] next_bresp;
	lsm_rd_state_t rd_state; // read channel state
	lsm_rd_state_t next_rd_state;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	logic [1:0] rresp;
	logic [1:0] next_rresp;
	logic pin_two; // registered pin levels
	logic next_pin_two;
	logic pin_three;
	logic next_pin_three;
	logic [1:0] wsel; // decode of captured write address
	logic [1:0] rsel; // decode of read address

	//------------------------------------------------------------------
	// handshake outputs
	//------------------------------------------------------------------
	// hold off new writes until the answer is taken: one write at a time
	assign s_axi_awready = !aw_held && !bvalid;
	assign s_axi_wready = !w_held && !bvalid;
	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;
	assign s_axi_arready = (rd_state == LSM_RD_IDLE);
	assign s_axi_rvalid = (rd_state == LSM_RD_RESP);
	assign s_axi_rdata = rdata;
	assign s_axi_rresp = rresp;
	assign indicator_pin_two = pin_two;
	assign indicator_pin_three = pin_three;
	assign wsel = lsm_sel(aw_addr);
	assign rsel = lsm_sel(s_axi_araddr);

	//------------------------------------------------------------------
	// write path and control registers
	//------------------------------------------------------------------
	// next values: capture address and data in either order, then commit
	always_comb begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_ctrl = ctrl;
		// answer taken
		if (bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		// address arrives
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		// data arrives; upper half has no storage
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata[15:0];
			next_w_strb = s_axi_wstrb[1:0];
		end
		// both present: commit, masks keep reserved and raw bits zero
		if (aw_held && w_held && !bvalid) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = (wsel != 2'h0) ? `LSM_RESP_OKAY : `LSM_RESP_SLVERR;
			if (wsel[0]) begin
				next_ctrl[0] = lsm_merge(ctrl[0], w_data, w_strb, `LSM_WMASK_TWO);
			end
			if (wsel[1]) begin
				next_ctrl[1] = lsm_merge(ctrl[1], w_data, w_strb, `LSM_WMASK_THREE);
			end
		end
	end

	// register the write path
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= 2'h0;
			bvalid <= 1'b0;
			bresp <= `LSM_RESP_OKAY;
			ctrl[0] <= `LSM_RST_TWO;
			ctrl[1] <= `LSM_RST_THREE;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			ctrl <= next_ctrl;
		end
	end

	//------------------------------------------------------------------
	// read path
	//------------------------------------------------------------------
	// next values: data latched at address acceptance, shown next cycle
	always_comb begin
		next_rd_state = rd_state;
		next_rdata = rdata;
		next_rresp = rresp;
		unique case (rd_state)
			LSM_RD_IDLE: begin
				if (s_axi_arvalid) begin
					next_rd_state = LSM_RD_RESP;
					next_rdata = 32'h0;
					next_rresp = (rsel != 2'h0) ? `LSM_RESP_OKAY : `LSM_RESP_SLVERR;
					// bit 15 shows the live unstretched state
					if (rsel[0]) begin
						next_rdata[15:0] = {raw[0], ctrl[0][14:0]};
					end
					if (rsel[1]) begin
						next_rdata[15:0] = {raw[1], ctrl[1][14:0]};
					end
				end
			end
			LSM_RD_RESP: begin
				if (s_axi_rready) begin
					next_rd_state = LSM_RD_IDLE;
				end
			end
		endcase
	end

	// register the read path
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rd_state <= LSM_RD_IDLE;
			rdata <= 32'h0;
			rresp <= `LSM_RESP_OKAY;
		end else begin
			rd_state <= next_rd_state;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end

	//------------------------------------------------------------------
	// event selection and pulse stretchers, one per led
	//------------------------------------------------------------------
	for (genvar i = 0; i < 2; i++) begin : g_led
		logic rx_term; // receive activity after address filter
		logic [`LSM_CNT_W-1:0] cnt; // stretch cycles remaining
		logic [`LSM_CNT_W-1:0] next_cnt;

		// address-match filter only gates receive activity
		assign rx_term = rx_activity && (!ctrl[i][`LSM_B_MATCH] || rx_addr_match);

		// or of all enabled functions
		assign raw[i] = (ctrl[i][`LSM_B_TX] && tx_activity)
			|| (ctrl[i][`LSM_B_POL] && polarity_good)
			|| (ctrl[i][`LSM_B_RCV] && rx_term)
			|| (ctrl[i][`LSM_B_JAB] && jabber)
			|| (ctrl[i][`LSM_B_COL] && collision);

		// reload while any event is active, count down after the last
		always_comb begin
			next_cnt = cnt;
			if (raw[i]) begin
				next_cnt = `LSM_CNT_W'(`LSM_STRETCH_CYC);
			end else if (cnt != '0) begin
				next_cnt = cnt - `LSM_CNT_W'(1);
			end
		end

		// register the stretch count
		always_ff @(posedge clk or posedge reset) begin
			if (reset) begin
				cnt <= '0;
			end else begin
				cnt <= next_cnt;
			end
		end

		// stretcher only lengthens when enabled
		assign lit[i] = raw[i] || (ctrl[i][`LSM_B_PSE] && cnt != '0);
	end

	//------------------------------------------------------------------
	// pin drivers
	//------------------------------------------------------------------
	// invert set: active high; clear: active low, so a lit led pulls low
	always_comb begin
		next_pin_two = ctrl[0][`LSM_B_INV] ? lit[0] : !lit[0];
		next_pin_three = !lit[1];
	end

	// pins idle high (unlit) through reset since invert resets clear
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pin_two <= 1'b1;
			pin_three <= 1'b1;
		end else begin
			pin_two <= next_pin_two;
			pin_three <= next_pin_three;
		end
	end

	//------------------------------------------------------------------
	// assertions and covers
	//------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	AST_TX_OR: assert property (
		tx_activity && ctrl[0][`LSM_B_TX] |-> raw[0]
	) else $error("enabled transmit activity did not raise led two");

	AST_COL_OR: assert property (
		collision && ctrl[1][`LSM_B_COL] && !ctrl[1][`LSM_B_INV] |=> !pin_three
	) else $error("enabled collision did not light led three");

	AST_RST_VALUES: assert property (
		$past(reset) |-> ctrl[0] == `LSM_RST_TWO && ctrl[1] == `LSM_RST_THREE
	) else $error("control registers not at reset defaults");

	AST_RAW_READ: assert property (
		s_axi_arvalid && s_axi_arready && s_axi_araddr == `LSM_OFS_TWO
		|=> s_axi_rvalid && s_axi_rdata[15] == $past(raw[0])
	) else $error("bit 15 read does not show raw state");

	AST_RESERVED_ZERO: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0 && s_axi_rdata[13:8] == 6'h0
			&& s_axi_rdata[6] == 1'b0
	) else $error("reserved read bits are not zero");

	AST_MATCH_FILTER: assert property (
		ctrl[1][5:0] == 6'h24 && !rx_addr_match |-> !raw[1]
	) else $error("unmatched receive lit a match-only led");

	AST_POL_BAD: assert property (
		polarity_good && ctrl[0][`LSM_B_POL] && ctrl[0][`LSM_B_INV] |=> pin_two
	) else $error("inverted good polarity did not drive pin high");

	AST_STRETCH_HOLD: assert property (
		raw[1] && ctrl[1][`LSM_B_PSE] ##1 !raw[1] && ctrl[1][`LSM_B_PSE]
		|=> !pin_three
	) else $error("stretch did not hold led three after event");

	AST_NO_STRETCH: assert property (
		!raw[1] && !ctrl[1][`LSM_B_PSE] |=> pin_three
	) else $error("led three lit without event or stretch");

	AST_POL_ENABLE: assert property (
		polarity_good && ctrl[1][`LSM_B_POL] |-> raw[1]
	) else $error("enabled good polarity did not raise led three");

	COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
	COV_READ: cover property (s_axi_rvalid && s_axi_rready);
	COV_STRETCH_END: cover property (lit[1] ##1 !lit[1]);
endmodule : lsm_led_status_mux

// ### verif/lsm_led_board.sv
// board indicator lamps watching the two controller pins
module lsm_led_board (
	// pins from the controller
	input wire logic pin_two,
	input wire logic pin_three,
	// lamp states seen by a viewer
	output logic lit_two,
	output logic lit_three
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// lamps
	// ----------------------------------------
	// the lamp sinks current whatever software chose: invert only flips the pin,
	// so an inverted good polarity leaves the lamp dark (polarity-bad lamp)
	assign lit_two = !pin_two;
	// pin three has no invert, always sinks current to light
	assign lit_three = !pin_three;
endmodule : lsm_led_board

// ### verif/led_status_mux_tb.sv
// self-checking bench for the led status mux
`include "lsm_consts.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
module led_status_mux_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, reset = 1;
	logic [3:0] awaddr = 0, araddr = 0, wstrb = 0;
	logic [31:0] wdata = 0, rdata;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, pin2, pin3, lit2, lit3;
	logic [1:0] bresp, rresp, resp;
	logic [5:0] ev = 0; // bit order matches the control field order
	logic [15:0] rd;
	int n_errors = 0, checks_done = 0;
	// ----------------------------------------
	// device and lamps
	// ----------------------------------------
	lsm_led_status_mux dut (.clk(clk), .reset(reset), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .tx_activity(ev[4]), .rx_activity(ev[2]),
		.rx_addr_match(ev[5]), .polarity_good(ev[3]), .jabber(ev[1]),
		.collision(ev[0]), .indicator_pin_two(pin2), .indicator_pin_three(pin3));
	lsm_led_board board (.pin_two(pin2), .pin_three(pin3),
		.lit_two(lit2), .lit_three(lit3));
	initial begin
		forever #25 clk = ~clk;
	end
	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	task automatic print_verdict;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : print_verdict
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	// write one word; handshake values are read before the edge's updates land
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		int i;
		@(posedge clk);
		awaddr <= a; wdata <= {16'h0000, d}; wstrb <= 4'hF;
		awvalid <= 1; wvalid <= 1; bready <= 1;
		for (i = 0; i < 100; i++) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 0;
			if (wvalid && wready) wvalid <= 0;
			if (bvalid) break;
		end
		resp = bresp;
		bready <= 0;
		if (i == 100) begin n_errors++; print_verdict(); end
	endtask : wr
	task automatic rdr(input logic [3:0] a);
		int i;
		@(posedge clk);
		araddr <= a; arvalid <= 1; rready <= 1;
		for (i = 0; i < 100; i++) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 0;
			if (rvalid) break;
		end
		rd = rdata[15:0]; resp = rresp;
		rready <= 0;
		if (i == 100) begin n_errors++; print_verdict(); end
	endtask : rdr
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		rdr(4'h0); `CHK("two reset", 16'h0088, rd)
		rdr(4'h4); `CHK("three reset", 16'h0090, rd)
		$display("test reset done");
	endtask : t_reset
	// reserved bits written as zero, read-only bit 15 written as one: it must read raw
	task automatic t_reserved;
		wr(4'h0, 16'hC0BF); rdr(4'h0); `CHK("two mask", 16'h40BF, rd)
		wr(4'h4, 16'h80BF); rdr(4'h4); `CHK("three mask", 16'h00BF, rd)
		wr(4'h8, 16'h0001); `CHK("bad wr", 2'h2, resp)
		rdr(4'h8); `CHK("bad rd", 2'h2, resp)
		$display("test reserved done");
	endtask : t_reserved
	// each function alone lights the lamp, all others together do not
	task automatic t_functions;
		for (int b = 0; b < 5; b++) begin
			wr(4'h4, 16'h0001 << b);
			ev <= 6'h01 << b; cyc(3);
			`CHK("lit", 1'b1, lit3)
			rdr(4'h4); `CHK("raw", 1'b1, rd[15])
			ev <= 6'h1F ^ (6'h01 << b); cyc(3);
			`CHK("off", 1'b0, lit3)
			ev <= 6'h00;
		end
		wr(4'h4, 16'h0007); ev <= 6'h03; cyc(3);
		`CHK("or set", 1'b0, pin3)
		ev <= 6'h00;
		$display("test functions done");
	endtask : t_functions
	task automatic t_match;
		wr(4'h4, 16'h0024); ev <= 6'h04; cyc(3);
		`CHK("no match", 1'b1, pin3)
		ev <= 6'h24; cyc(3);
		`CHK("match", 1'b0, pin3)
		ev <= 6'h00;
		$display("test match done");
	endtask : t_match
	task automatic t_polarity;
		ev <= 6'h08;
		wr(4'h0, 16'h4008); cyc(3);
		`CHK("bad lamp", 1'b1, pin2)
		`CHK("unlit", 1'b0, lit2)
		wr(4'h0, 16'h0008); cyc(3);
		`CHK("good lamp", 1'b0, pin2)
		wr(4'h0, 16'h4000); cyc(3);
		`CHK("ignored", 1'b0, pin2)
		ev <= 6'h00;
		$display("test polarity done");
	endtask : t_polarity
	// second pulse in mid-stretch must restart the hold time
	task automatic t_stretch;
		wr(4'h4, 16'h0081);
		ev <= 6'h01; cyc(1); ev <= 6'h00;
		cyc(`LSM_STRETCH_CYC / 2);
		ev <= 6'h01; cyc(1); ev <= 6'h00;
		cyc(`LSM_STRETCH_CYC - 10);
		`CHK("held", 1'b1, lit3)
		cyc(20);
		`CHK("ended", 1'b0, lit3)
		rdr(4'h4); `CHK("raw low", 1'b0, rd[15])
		$display("test stretch done");
	endtask : t_stretch
	initial begin
		cyc(12);
		reset <= 0;
		t_reset();
		t_reserved();
		t_functions();
		t_match();
		t_polarity();
		t_stretch();
		print_verdict();
	end
endmodule : led_status_mux_tb
